// File: smbus_transfer_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "smbus_seq_regs.svh"
// What this block does
// - four modes; master from generated start until stop or lost arbitration
// - byte event raised before ack when receiving, after ack when sending
// - master transmit: start, address with write direction, acknowledged data bytes
// - master transfer ends when software sets stop request, then stop sent, or when arbitration is lost
// - no buffer write after master transmit event switches to master receive
// - master receive: start, address with read direction, clock in slave data
// - each byte received as master sets ack request; ack bit 1 acks, 0 nacks
// - buffer write while active master receiver leaves master receive
// - uninhibited slave address match with write sets ack request and event
// - nacked slave address suppresses slave events until next start
// - slave receiver sets ack request for each byte; leaves slave receive on stop
// - buffer write while active slave receiver switches to slave transmit
// - address with read sets ack request; after ack and load, transmit bytes
// - no buffer write after slave transmit event falls back to slave receive
// - status vector is master, transmit direction, start request, stop request
// - status 1110 without ack request marks a generated master start
// - after ack: load, stop, stop plus start, repeated start, or receive
// - bytes go out most significant bit first and land the same way
// - ack request clears after each acknowledge cycle
module smbus_transfer_mode_sequencer #(
  parameter int SCL_HALF_NS = `SCL_HALF_NS,
  parameter int CLK_PERIOD_NS = `CLK_PERIOD_NS,
  parameter int DATA_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [6:0] own_address_i,
  input wire logic slave_inhibit_bit_i,
  input wire logic control_write_i,
  input wire smbus_seq_pkg::control_write_t control_i,
  input wire logic byte_event_clear_i,
  input wire logic buffer_write_i,
  input wire logic [DATA_W-1:0] buffer_data_i,
  output smbus_seq_pkg::status_vector_t status_vector_o,
  output logic ack_request_flag_o,
  output logic arbitration_lost_flag_o,
  output logic ack_received_o,
  output logic byte_event_o,
  output logic [DATA_W-1:0] serial_byte_buffer_o,
  output logic rx_valid_o,
  output logic [DATA_W-1:0] rx_data_o,
  input wire logic rx_ready_i
);
  // half scl period is a least time, so round up
  localparam logic [15:0] HALF_CYC = 16'((SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BITS = 4'(DATA_W);

  smbus_seq_pkg::seq_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [15:0] div_reg, div_next;
  logic scl_hi_reg, scl_hi_next, scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic [DATA_W-1:0] shift_reg, shift_next, wdata_reg, wdata_next;
  logic master_reg, master_next, txdir_reg, txdir_next;
  logic start_req_reg, start_req_next, stop_req_reg, stop_req_next;
  logic ack_bit_reg, ack_bit_next, ack_request_flag_reg, ack_request_flag_next, arb_reg, arb_next;
  logic si_reg, si_next, ackrx_reg, ackrx_next, addr_reg, addr_next;
  logic suppress_reg, suppress_next, wrp_reg, wrp_next, pushp_reg, pushp_next;
  logic out_v_reg, out_v_next, sp_v_reg, sp_v_next;
  logic [DATA_W-1:0] out_d_reg, out_d_next, sp_d_reg, sp_d_next;
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic tick, rise_ev, fall_ev, start_det, stop_det, own_cond, match, advance, push;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3} <= 6'h3f;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
    end
  end

  assign tick = (div_reg == HALF_CYC - 16'h1);
  // master paces bits from its divider, a slave follows edges seen on the line
  assign rise_ev = master_reg ? (tick && !scl_hi_reg) : (scl_s2 && !scl_s3);
  assign fall_ev = master_reg ? (tick && scl_hi_reg) : (!scl_s2 && scl_s3);
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign own_cond = master_reg || state_reg == smbus_seq_pkg::ST_START
                    || state_reg == smbus_seq_pkg::ST_STOP;
  assign match = (shift_reg[DATA_W-1:1] == own_address_i) && !slave_inhibit_bit_i
                 && !suppress_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    scl_hi_next = scl_hi_reg;
    sda_oe_next = sda_oe_reg;
    shift_next = shift_reg;
    master_next = master_reg;
    txdir_next = txdir_reg;
    start_req_next = start_req_reg;
    stop_req_next = stop_req_reg;
    ack_bit_next = ack_bit_reg;
    ack_request_flag_next = ack_request_flag_reg;
    arb_next = arb_reg;
    si_next = si_reg;
    ackrx_next = ackrx_reg;
    addr_next = addr_reg;
    suppress_next = suppress_reg;
    pushp_next = pushp_reg;
    push = 1'b0;
    advance = 1'b0;
    wrp_next = wrp_reg || (buffer_write_i && si_reg);
    wdata_next = (buffer_write_i && si_reg) ? buffer_data_i : wdata_reg;
    div_next = (tick || (scl_hi_reg && !scl_s2)) ? 16'h0 : div_reg + 16'h1;
    if (control_write_i) begin
      start_req_next = control_i.start_request_bit;
      stop_req_next = control_i.stop_request_bit;
      ack_bit_next = control_i.ack_bit;
    end
    if (byte_event_clear_i) begin
      si_next = 1'b0;
      arb_next = 1'b0;
    end
    case (state_reg)
      smbus_seq_pkg::ST_IDLE: begin
        div_next = 16'h0;
        if (start_req_next) begin
          state_next = smbus_seq_pkg::ST_START;
          cnt_next = 4'h0;
        end
      end
      smbus_seq_pkg::ST_START: begin
        scl_hi_next = (cnt_reg == `PHASE_SCL_HIGH) || (cnt_reg == `PHASE_SDA_LOW);
        sda_oe_next = (cnt_reg >= `PHASE_SDA_LOW);
        if (tick) begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `PHASE_LAST_START) begin
            master_next = 1'b1;
            txdir_next = 1'b1;
            si_next = 1'b1;
            addr_next = 1'b1;
            state_next = smbus_seq_pkg::ST_HOLD;
          end
        end
      end
      smbus_seq_pkg::ST_DATA: begin
        if (master_reg && tick) begin
          scl_hi_next = !scl_hi_reg;
        end
        if (rise_ev) begin
          shift_next = {shift_reg[DATA_W-2:0], sda_s2};
          cnt_next = cnt_reg + 4'h1;
          // a released one read back low means another master won
          if (master_reg && txdir_reg && shift_reg[DATA_W-1] && !sda_s2) begin
            arb_next = 1'b1;
            master_next = 1'b0;
            txdir_next = 1'b0;
            si_next = 1'b1;
            state_next = smbus_seq_pkg::ST_IDLE;
          end
        end else if (fall_ev) begin
          if (cnt_reg != BITS) begin
            sda_oe_next = txdir_reg && !shift_reg[DATA_W-1];
          end else if (addr_reg && !master_reg) begin
            if (match) begin
              si_next = 1'b1;
              ack_request_flag_next = 1'b1;
              start_req_next = 1'b1;
              state_next = smbus_seq_pkg::ST_HOLD;
            end else begin
              state_next = smbus_seq_pkg::ST_IDLE;
            end
          end else if (txdir_reg) begin
            sda_oe_next = 1'b0;
            state_next = smbus_seq_pkg::ST_ACK;
          end else begin
            ack_request_flag_next = 1'b1;
            pushp_next = 1'b1;
            state_next = smbus_seq_pkg::ST_HOLD;
          end
        end
      end
      smbus_seq_pkg::ST_ACK: begin
        if (master_reg && tick) begin
          scl_hi_next = !scl_hi_reg;
        end
        if (rise_ev && txdir_reg) begin
          ackrx_next = !sda_s2;
        end else if (fall_ev) begin
          if (txdir_reg) begin
            si_next = 1'b1;
            state_next = smbus_seq_pkg::ST_HOLD;
          end else begin
            sda_oe_next = 1'b0;
            ack_request_flag_next = 1'b0;
            if (addr_reg && !master_reg && !ack_bit_reg) begin
              suppress_next = 1'b1;
              state_next = smbus_seq_pkg::ST_IDLE;
            end else begin
              advance = 1'b1;
            end
          end
        end
      end
      smbus_seq_pkg::ST_HOLD: begin
        div_next = 16'h0;
        // a full receive buffer keeps the bus stretched until it drains
        if (pushp_reg && !sp_v_reg) begin
          push = 1'b1;
          pushp_next = 1'b0;
          si_next = 1'b1;
        end
        if (si_reg && byte_event_clear_i) begin
          if (ack_request_flag_reg) begin
            sda_oe_next = ack_bit_next;
            state_next = smbus_seq_pkg::ST_ACK;
          end else begin
            advance = 1'b1;
          end
        end
      end
      smbus_seq_pkg::ST_STOP: begin
        scl_hi_next = (cnt_reg != 4'h0);
        sda_oe_next = (cnt_reg != `PHASE_LAST_STOP);
        if (tick) begin
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == `PHASE_LAST_STOP) begin
            master_next = 1'b0;
            txdir_next = 1'b0;
            stop_req_next = 1'b0;
            cnt_next = 4'h0;
            state_next = start_req_next ? smbus_seq_pkg::ST_START : smbus_seq_pkg::ST_IDLE;
          end
        end
      end
      default: state_next = smbus_seq_pkg::ST_IDLE;
    endcase
    if (advance) begin
      addr_next = 1'b0;
      cnt_next = 4'h0;
      if (master_reg && stop_req_next) begin
        state_next = smbus_seq_pkg::ST_STOP;
      end else if (master_reg && start_req_next) begin
        state_next = smbus_seq_pkg::ST_START;
      end else if (wrp_next) begin
        txdir_next = 1'b1;
        shift_next = wdata_next;
        wrp_next = 1'b0;
        sda_oe_next = !wdata_next[DATA_W-1];
        state_next = smbus_seq_pkg::ST_DATA;
      end else begin
        txdir_next = 1'b0;
        sda_oe_next = 1'b0;
        state_next = smbus_seq_pkg::ST_DATA;
      end
    end
    if (!own_cond && start_det) begin
      suppress_next = 1'b0;
      txdir_next = 1'b0;
      addr_next = 1'b1;
      cnt_next = 4'h0;
      sda_oe_next = 1'b0;
      state_next = smbus_seq_pkg::ST_DATA;
    end else if (!own_cond && stop_det && state_reg != smbus_seq_pkg::ST_IDLE) begin
      txdir_next = 1'b0;
      sda_oe_next = 1'b0;
      state_next = smbus_seq_pkg::ST_IDLE;
    end
    if (state_next == smbus_seq_pkg::ST_IDLE) begin
      scl_hi_next = 1'b1;
      sda_oe_next = 1'b0;
    end else if (state_next == smbus_seq_pkg::ST_HOLD) begin
      scl_hi_next = 1'b0;
    end
    scl_oe_next = 1'b0;
    if (state_next == smbus_seq_pkg::ST_HOLD) begin
      scl_oe_next = 1'b1;
    end else if (state_next != smbus_seq_pkg::ST_IDLE && (master_next
                 || state_next == smbus_seq_pkg::ST_START
                 || state_next == smbus_seq_pkg::ST_STOP)) begin
      scl_oe_next = !scl_hi_next;
    end
  end

  always_comb begin
    out_v_next = out_v_reg;
    out_d_next = out_d_reg;
    sp_v_next = sp_v_reg;
    sp_d_next = sp_d_reg;
    if (out_v_reg && rx_ready_i) begin
      out_v_next = sp_v_reg;
      out_d_next = sp_d_reg;
      sp_v_next = 1'b0;
    end
    if (push) begin
      if (!out_v_next) begin
        out_v_next = 1'b1;
        out_d_next = shift_reg;
      end else begin
        sp_v_next = 1'b1;
        sp_d_next = shift_reg;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= smbus_seq_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      div_reg <= 16'h0;
      scl_hi_reg <= 1'b1;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      shift_reg <= '0;
      wdata_reg <= '0;
      {master_reg, txdir_reg, start_req_reg, stop_req_reg} <= 4'h0;
      {ack_bit_reg, ack_request_flag_reg, arb_reg, si_reg, ackrx_reg} <= 5'h00;
      {addr_reg, suppress_reg, wrp_reg, pushp_reg} <= 4'h0;
      {out_v_reg, sp_v_reg} <= 2'h0;
      out_d_reg <= '0;
      sp_d_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      scl_hi_reg <= scl_hi_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      shift_reg <= shift_next;
      wdata_reg <= wdata_next;
      {master_reg, txdir_reg} <= {master_next, txdir_next};
      {start_req_reg, stop_req_reg} <= {start_req_next, stop_req_next};
      {ack_bit_reg, ack_request_flag_reg, arb_reg} <= {ack_bit_next, ack_request_flag_next, arb_next};
      {si_reg, ackrx_reg} <= {si_next, ackrx_next};
      {addr_reg, suppress_reg, wrp_reg, pushp_reg} <=
        {addr_next, suppress_next, wrp_next, pushp_next};
      {out_v_reg, sp_v_reg} <= {out_v_next, sp_v_next};
      out_d_reg <= out_d_next;
      sp_d_reg <= sp_d_next;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_oe_reg;
  assign sda_oe_o = sda_oe_reg;
  assign status_vector_o = {master_reg, txdir_reg, start_req_reg, stop_req_reg};
  assign ack_request_flag_o = ack_request_flag_reg;
  assign arbitration_lost_flag_o = arb_reg;
  assign ack_received_o = ackrx_reg;
  assign byte_event_o = si_reg;
  assign serial_byte_buffer_o = shift_reg;
  assign rx_valid_o = out_v_reg;
  assign rx_data_o = out_d_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_master_entry: assert property ($rose(master_reg) |->
    $past(state_reg) == smbus_seq_pkg::ST_START && byte_event_o && txdir_reg)
    else $error("master mode entered without a generated start");
  a_master_exit: assert property ($fell(master_reg) |->
    arbitration_lost_flag_o || $past(state_reg) == smbus_seq_pkg::ST_STOP)
    else $error("master mode left without stop or lost arbitration");
  a_start_status: assert property ($rose(master_reg) && start_req_reg |->
    status_vector_o == 4'he && !ack_request_flag_o && !arbitration_lost_flag_o)
    else $error("generated start not shown as status 1110");
  a_stop_only: assert property ($fell(stop_req_reg) && !$past(control_write_i) |->
    $past(state_reg) == smbus_seq_pkg::ST_STOP && !master_reg)
    else $error("stop request cleared without a stop");
  a_rx_event_early: assert property ($rose(ack_request_flag_o) |->
    state_reg == smbus_seq_pkg::ST_HOLD && scl_oe_o && !txdir_reg)
    else $error("receive event not held before ack cycle");
  a_ack_request_flag_clear: assert property ($fell(ack_request_flag_o) |->
    $past(state_reg) == smbus_seq_pkg::ST_ACK)
    else $error("ack request cleared outside an ack cycle");
  a_hold_stretch: assert property (byte_event_o && state_reg == smbus_seq_pkg::ST_HOLD
    && !byte_event_clear_i |=> scl_oe_o)
    else $error("scl released while byte event set");
  a_rx_switch: assert property (state_reg == smbus_seq_pkg::ST_HOLD && master_reg
    && txdir_reg && !ack_request_flag_reg && si_reg && byte_event_clear_i && !stop_req_reg
    && !start_req_reg && !wrp_reg && !buffer_write_i && !pushp_reg
    && !(control_write_i && (control_i.start_request_bit || control_i.stop_request_bit))
    |=> !txdir_reg && state_reg == smbus_seq_pkg::ST_DATA && !sda_oe_o)
    else $error("no master receive after unloaded transmit event");
  a_rx_to_tx: assert property (state_reg == smbus_seq_pkg::ST_ACK && fall_ev
    && !txdir_reg && master_reg && wrp_reg && !stop_req_reg && !start_req_reg
    && !control_write_i |=> txdir_reg && state_reg == smbus_seq_pkg::ST_DATA)
    else $error("buffer write did not leave master receive");
  a_slave_addr: assert property (state_reg == smbus_seq_pkg::ST_DATA && fall_ev
    && addr_reg && !own_cond && cnt_reg == BITS && match && !start_det && !stop_det
    |=> ack_request_flag_o && byte_event_o && scl_oe_o)
    else $error("matched slave address not reported");
  a_suppress: assert property ($rose(byte_event_o) && !master_reg &&
    !arbitration_lost_flag_o |-> !$past(suppress_reg, 2))
    else $error("slave event while suppressed");
  a_msb_out: assert property (state_reg == smbus_seq_pkg::ST_DATA && txdir_reg &&
    fall_ev && cnt_reg != BITS && !start_det && !stop_det
    |=> sda_oe_o == !$past(shift_reg[DATA_W-1]))
    else $error("transmit bit not taken from the top of the shifter");

  c_master_start: cover property ($rose(master_reg));
  c_slave_addr: cover property ($rose(ack_request_flag_o) && !master_reg);
  c_rx_full: cover property (rx_valid_o && !rx_ready_i ##1 sp_v_reg);
endmodule
`default_nettype wire

// File: smbus_seq_regs.svh
`ifndef SMBUS_SEQ_REGS_SVH
`define SMBUS_SEQ_REGS_SVH
`define CLK_PERIOD_NS 8
`define SCL_HALF_NS 5000
`define PHASE_LAST_START 4'h3
`define PHASE_LAST_STOP 4'h2
`define PHASE_SCL_HIGH 4'h1
`define PHASE_SDA_LOW 4'h2
`define ADDR_DIR_BIT 0
`endif

// File: smbus_seq_pkg.sv
`default_nettype none
package smbus_seq_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_ACK, ST_HOLD, ST_STOP} seq_state_t;
  typedef struct packed {
    logic master_flag;
    logic transmit_direction_flag;
    logic start_request_bit;
    logic stop_request_bit;
  } status_vector_t;
  typedef struct packed {
    logic start_request_bit;
    logic stop_request_bit;
    logic ack_bit;
  } control_write_t;
endpackage
`default_nettype wire

// File: smbus_far_master.sv
`timescale 1ns/1ps
`default_nettype none
module smbus_far_master #(
  parameter int HALF = 5
) (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  task automatic half_wait();
    repeat (HALF) @(posedge clk_i);
  endtask
  // the device may stretch scl; the wait is bounded so a stuck line cannot hang the run
  task automatic scl_release();
    int n;
    n = 0;
    scl_oe_o <= 1'b0;
    @(posedge clk_i);
    while (scl_i !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    half_wait();
  endtask
  // sda moves one cycle after scl falls so the two edges never meet in the synchronisers
  task automatic bit_io(input logic lvl, output logic seen);
    @(posedge clk_i);
    sda_oe_o <= ~lvl;
    half_wait();
    scl_release();
    seen = sda_i;
    scl_oe_o <= 1'b1;
  endtask
  task automatic start_cond();
    sda_oe_o <= 1'b1;
    half_wait();
    scl_oe_o <= 1'b1;
  endtask
  task automatic stop_cond();
    @(posedge clk_i);
    sda_oe_o <= 1'b1;
    half_wait();
    scl_release();
    sda_oe_o <= 1'b0;
    half_wait();
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack_lvl);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack_lvl);
  endtask
  // ack_lvl 1 leaves sda released, the nack that closes a read
  task automatic recv_byte(input logic ack_lvl, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(ack_lvl, s);
  endtask
  // stands in for an addressed slave: acks the next byte the line carries
  task automatic slave_ack();
    repeat (8) @(posedge scl_i);
    @(negedge scl_i);
    @(posedge clk_i);
    sda_oe_o <= 1'b1;
    @(negedge scl_i);
    @(posedge clk_i);
    sda_oe_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test_smbus_transfer_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_smbus_transfer_mode_sequencer;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl_oe, sda_oe, p_scl_oe, p_sda_oe;
  wire logic scl_w = ~(scl_oe | p_scl_oe);
  wire logic sda_w = ~(sda_oe | p_sda_oe);
  logic [6:0] own_address_i = 7'h00;
  logic slave_inhibit_bit_i = 1'b0;
  logic control_write_i = 1'b0;
  smbus_seq_pkg::control_write_t control_i = '0;
  logic byte_event_clear_i = 1'b0;
  logic buffer_write_i = 1'b0;
  logic [7:0] buffer_data_i = 8'h00;
  logic rx_ready_i = 1'b0;
  smbus_seq_pkg::status_vector_t status_vector_o;
  logic ack_request_flag_o, arbitration_lost_flag_o, ack_received_o, byte_event_o, rx_valid_o;
  logic [7:0] serial_byte_buffer_o, rx_data_o;
  logic [8:0] mon;
  logic [31:0] rnd = 32'h495b;
  logic ev_d = 1'b0;
  int ev_count = 0;
  int cycles = 0;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] rx_q[$];

  smbus_transfer_mode_sequencer #(.SCL_HALF_NS(40)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .own_address_i(own_address_i),
    .slave_inhibit_bit_i(slave_inhibit_bit_i), .control_write_i(control_write_i),
    .control_i(control_i), .byte_event_clear_i(byte_event_clear_i),
    .buffer_write_i(buffer_write_i), .buffer_data_i(buffer_data_i),
    .status_vector_o(status_vector_o), .ack_request_flag_o(ack_request_flag_o),
    .arbitration_lost_flag_o(arbitration_lost_flag_o), .ack_received_o(ack_received_o),
    .byte_event_o(byte_event_o), .serial_byte_buffer_o(serial_byte_buffer_o),
    .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i)
  );
  smbus_far_master #(.HALF(5)) p (
    .clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(p_scl_oe), .sda_oe_o(p_sda_oe)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sw_wait(input logic [3:0] st, input logic rq);
    int n;
    n = 0;
    // the clear edge has not yet reached byte_event_o, so look half a cycle later
    @(negedge clk_i);
    while (byte_event_o !== 1'b1 && n < 8000) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    check(n < 8000, 1'b1);
    check(status_vector_o, st);
    check(ack_request_flag_o, rq);
  endtask
  task automatic sw_pulse(input logic [2:0] ctl, input logic wr, input logic [7:0] d,
                          input logic clr);
    @(posedge clk_i);
    control_i <= ctl;
    control_write_i <= 1'b1;
    buffer_write_i <= wr;
    buffer_data_i <= d;
    byte_event_clear_i <= clr;
    @(posedge clk_i);
    control_write_i <= 1'b0;
    buffer_write_i <= 1'b0;
    byte_event_clear_i <= 1'b0;
  endtask

  always #4 clk_i = ~clk_i;
  always @(posedge scl_w) mon <= {mon[7:0], sda_w};
  // the consumer stalls at random, but never long enough for the two-entry buffer to fill
  always @(posedge clk_i) begin
    rnd <= lfsr_next(rnd);
    rx_ready_i <= rnd[2] | rnd[6];
    if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
      rx_q.push_back(rx_data_o);
    end
    ev_d <= byte_event_o;
    if (byte_event_o === 1'b1 && ev_d !== 1'b1) begin
      ev_count <= ev_count + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0] d[3];
    logic ak[3];
    logic a, a2;
    logic [7:0] rd;
    logic [6:0] own;
    logic [31:0] r;
    int ev0;
    int n;
    r = lfsr_next(32'h495b);
    own = r[14:8];
    for (int i = 0; i < 3; i++) begin
      r = lfsr_next(r);
      d[i] = r[7:0];
    end
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    own_address_i <= own;
    repeat (3) @(posedge clk_i);
    fork
      begin
        p.start_cond();
        p.send_byte({own, 1'b0}, a);
        for (int i = 0; i < 3; i++) p.send_byte(d[i], ak[i]);
        p.stop_cond();
      end
      begin
        sw_wait(4'b0010, 1'b1);
        sw_pulse(3'b001, 1'b0, 8'h00, 1'b1);
        for (int i = 0; i < 3; i++) begin
          sw_wait(4'b0000, 1'b1);
          sw_pulse({2'b00, i != 2}, 1'b0, 8'h00, 1'b1);
        end
      end
    join
    check(a, 1'b0);
    for (int i = 0; i < 3; i++) check(ak[i], i == 2);
    check(ack_request_flag_o, 1'b0);
    check(byte_event_o, 1'b0);
    n = 0;
    while (rx_q.size() < 3 && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    check(rx_q.size(), 3);
    for (int i = 0; i < 3 && i < rx_q.size(); i++) check(rx_q[i], d[i]);
    r = lfsr_next(r);
    fork
      begin
        p.start_cond();
        p.send_byte({own, 1'b1}, a);
        p.recv_byte(1'b1, rd);
        p.stop_cond();
      end
      begin
        sw_wait(4'b0010, 1'b1);
        sw_pulse(3'b001, 1'b1, r[7:0], 1'b1);
        sw_wait(4'b0100, 1'b0);
        check(ack_received_o, 1'b0);
        sw_pulse(3'b000, 1'b0, 8'h00, 1'b1);
      end
    join
    check(a, 1'b0);
    check(rd, r[7:0]);
    check(status_vector_o.transmit_direction_flag, 1'b0);
    ev0 = ev_count;
    r = lfsr_next(r);
    fork
      begin
        p.start_cond();
        p.send_byte({own, 1'b0}, a);
        p.send_byte(r[7:0], a2);
        p.stop_cond();
      end
      begin
        sw_wait(4'b0010, 1'b1);
        sw_pulse(3'b000, 1'b0, 8'h00, 1'b1);
      end
    join
    check(a, 1'b1);
    check(a2, 1'b1);
    check(ev_count, ev0 + 1);
    slave_inhibit_bit_i <= 1'b1;
    ev0 = ev_count;
    p.start_cond();
    p.send_byte({own, 1'b0}, a);
    p.stop_cond();
    check(a, 1'b1);
    check(ev_count, ev0);
    slave_inhibit_bit_i <= 1'b0;
    r = lfsr_next(r);
    sw_pulse(3'b100, 1'b0, 8'h00, 1'b0);
    sw_wait(4'b1110, 1'b0);
    sw_pulse(3'b000, 1'b1, {r[6:0], 1'b0}, 1'b1);
    sw_wait(4'b1100, 1'b0);
    check(mon, {r[6:0], 1'b0, 1'b1});
    check(ack_received_o, 1'b0);
    check(serial_byte_buffer_o, {r[6:0], 1'b0});
    sw_pulse(3'b100, 1'b0, 8'h00, 1'b1);
    sw_wait(4'b1110, 1'b0);
    fork
      p.slave_ack();
      sw_pulse(3'b000, 1'b1, {r[14:8], 1'b1}, 1'b1);
    join
    sw_wait(4'b1100, 1'b0);
    check(ack_received_o, 1'b1);
    sw_pulse(3'b000, 1'b0, 8'h00, 1'b1);
    sw_wait(4'b1000, 1'b1);
    check(mon, 9'h0ff);
    check(serial_byte_buffer_o, 8'hff);
    sw_pulse(3'b001, 1'b1, r[23:16], 1'b1);
    sw_wait(4'b1100, 1'b0);
    check(serial_byte_buffer_o, r[23:16]);
    sw_pulse(3'b010, 1'b0, 8'h00, 1'b1);
    n = 0;
    while (status_vector_o.master_flag !== 1'b0 && n < 500) begin
      @(negedge clk_i);
      n++;
    end
    repeat (20) @(negedge clk_i);
    check(status_vector_o, 4'b0000);
    check({scl_w, sda_w}, 2'b11);
    check(rx_q.size(), 4);
    check(rx_q[3], 8'hff);
    print_verdict();
  end
endmodule
`default_nettype wire
